/* rtl/adc_port_params.svh */
/*
  Constants of the converter control port: reset values, timing and result format.
  Assumes a 20 MHz system clock; included by the control port module.
*/
`ifndef ADC_PORT_PARAMS_SVH
`define ADC_PORT_PARAMS_SVH

`define RESET_CLK_EXT     1'b1
`define CLK_PERIOD_NS     50
`define CONV_TIME_NS      3600
`define CONV_CLOCKS       13
`define ACQ_CLOCKS        3
`define INT_TICK_CYCLES   ((`CONV_TIME_NS) / ((`CONV_CLOCKS) * (`CLK_PERIOD_NS)))
`define RESET_TIME_NS     10000
`define RESET_CYCLES      (((`RESET_TIME_NS) + (`CLK_PERIOD_NS) - 1) / (`CLK_PERIOD_NS))
`define RESULT_BITS       12
`define SAR_START         12'h800
`define BIPOLAR_FLIP      12'h800

`endif

/* rtl/adc_port_pkg.sv */
/*
  Types of the converter control port: control byte layout and sequencer states.
  Assumes nothing of its surroundings.
*/
package adc_port_pkg;

  typedef struct packed {
    logic       powerModeHi;
    logic       powerModeLo;
    logic       acquisitionModeSel;
    logic       singleEndedSel;
    logic       unipolarSel;
    logic [2:0] channelAddr;
  } control_byte_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ACQ  = 2'b01,
    ST_CONV = 2'b11,
    ST_DONE = 2'b10
  } conv_state_type;

endpackage

/* rtl/result_if.sv */
/*
  Valid/ready carrier between the sequencer and its result buffer.
  Assumes one clock shared by both ends.
*/
`timescale 1ns/1ps
`default_nettype none

interface result_if #(parameter int WIDTH = 13);
  logic             inValid;
  logic             inReady;
  logic [WIDTH-1:0] inData;
  logic             outValid;
  logic             outReady;
  logic [WIDTH-1:0] outData;

  modport producer (output inValid, inData, outReady, input inReady, outValid, outData);
  modport store (input inValid, inData, outReady, output inReady, outValid, outData);
endinterface

`default_nettype wire

/* rtl/result_buffer.sv */
/*
  Small FIFO holding finished conversion results until the host reads them.
  Assumes DEPTH a power of two; the producer stalls while inReady is low.
*/
`timescale 1ns/1ps
`default_nettype none

module result_buffer #(
  parameter int WIDTH = 13,
  parameter int DEPTH = 2
) (
  input wire logic clk,
  input wire logic rst_b,
  result_if.store  port
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("DEPTH must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wrPtr_q;
  logic [AW-1:0]    rdPtr_q;
  logic [AW:0]      count_q;
  logic             push;
  logic             pop;

  assign port.inReady  = count_q != (AW+1)'(DEPTH);
  assign port.outValid = count_q != '0;
  assign port.outData  = mem_q[rdPtr_q];
  assign push = port.inValid && port.inReady;
  assign pop  = port.outValid && port.outReady;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wrPtr_q] <= port.inData;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wrPtr_q <= wrPtr_q + 1'b1;
      end
      if (pop) begin
        rdPtr_q <= rdPtr_q + 1'b1;
      end
      if (push && !pop) begin
        count_q <= count_q + 1'b1;
      end else if (pop && !push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

/* rtl/adc_parallel_control_port.sv */
/*
  Control port and conversion sequencer of a 12-bit successive-approximation converter:
  control byte capture, clock and power modes, SAR timing and byte-wide result read-back.
  Assumes all pins synchronous to clk and a comparator that settles within one clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "adc_port_params.svh"

// Contract
// R1: Control bits 7,6 = 1,0 select the internal conversion clock.
// R2: Control bits 7,6 = 1,1 select the external conversion clock.
// R3: A power-down control byte leaves the clock mode unchanged.
// R4: After power-up the external clock mode is in force.
// R5: Internal clock mode completes a conversion in about 3.6 us; the code takes 13 ticks of 5 clocks, 65 clocks or 3.25 us.
// R6: Host supplies 100 kHz to 4.8 MHz external clock, 30-70 percent duty.
// R7: Chip select high ignores clock and strobes and floats the bus.
// R8: A write captures the control byte from the eight data lines.
// R9: Byte layout: power hi, power lo, acquisition, single-ended, unipolar, channel.
// R10: Unipolar results are straight binary, bipolar results two's complement.
// R11: Reads need select and read low; byte select picks low or high.
// R12: High byte upper lines read zero unipolar, copies of bit 11 bipolar.
// R13: Single-ended: channel n positive against common; 4-7 only on eight channels.
// R14: Differential: bits 2,1 pick a pair, bit 0 picks which is positive.
// R15: Reset forces external clock and done high; no conversion for 10 us.
// R16: Host waits 500 us (internal reference) or 50 us before trusting results.
// R17: In either power-down state the port works but nothing converts.
// R18: Standby ends at the next rising write strobe.
// R19: Shutdown starts after the running conversion; a write strobe ends it.
// R20: Host enters standby through one dummy conversion requesting standby.
// R21: Code transitions lie halfway between integer LSB levels.
// R22: Power bits: 00 shutdown, 01 standby, 10 internal clock, 11 external.
// R23: Every conversion lasts 13 conversion-clock cycles.
// R24: Done goes low on a finished result, high on read or write.
// R25: A write during a conversion aborts it and starts a fresh acquisition.
// R26: Host drives the bus only writing; device only while reading.
module adc_parallel_control_port
  import adc_port_pkg::*;
#(
  parameter int NUM_CHANNELS = 8,
  parameter int BUF_DEPTH    = 2
) (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       chipSelect_b,
  input  wire logic       writeStrobe_b,
  input  wire logic       readStrobe_b,
  input  wire logic       byteHighSelect,
  input  wire logic       extConvClk,
  input  wire logic [7:0] dataIn,
  input  wire logic       compHigh,
  output logic      [7:0] dataOut_q,
  output logic            dataOe_q,
  output logic            convDone_b_q,
  output logic            trackHold_q,
  output logic     [12:0] dacLevel_q,
  output logic      [2:0] posChannel_q,
  output logic      [2:0] negChannel_q,
  output logic            negIsCommon_q,
  output logic            standby_q,
  output logic            shutdown_q,
  output logic            clockExt_q
);

  localparam int DIV   = `INT_TICK_CYCLES;
  localparam int DW    = $clog2(DIV + 1);
  localparam int RW    = $clog2(`RESET_CYCLES + 1);
  localparam int MSB   = `RESULT_BITS - 1;
  localparam int RES_W = `RESULT_BITS + 1;
  localparam logic [2:0] CH_MASK = 3'(NUM_CHANNELS - 1);

  if (NUM_CHANNELS != 4 && NUM_CHANNELS != 8) begin : g_bad_channels
    $error("NUM_CHANNELS must be 4 or 8");
  end

  logic             writing;
  logic             reading;
  logic             writeEvent;
  logic             readStart;
  logic             intTick;
  logic             extTick;
  logic             tick;
  logic             push;
  logic             startConv;
  logic             writeActive_q;
  logic             extPrev_q;
  logic             resetDone_q;
  logic             lastHigh_q;
  logic             extAcqHold_q;
  logic             cfgUni_q;
  logic             pendStandby_q;
  logic             pendShutdown_q;
  logic [RW-1:0]    resetCnt_q;
  logic [DW-1:0]    intDiv_q;
  logic [3:0]       cnt_q;
  logic [6:0]       convCycles_q;
  logic [MSB:0]     sar_q;
  logic [MSB:0]     trial_q;
  logic [MSB:0]     sarD;
  logic [RES_W-1:0] headWord;
  control_byte_type ctrlLatch_q;
  conv_state_type   state_q;

  result_if #(.WIDTH(RES_W)) res ();

  result_buffer #(.WIDTH(RES_W), .DEPTH(BUF_DEPTH)) result_buffer_inst (
    .clk   (clk),
    .rst_b (rst_b),
    .port  (res.store)
  );

  assign writing    = !chipSelect_b && !writeStrobe_b;
  assign reading    = !chipSelect_b && !readStrobe_b;          // see R11
  assign writeEvent = writeActive_q && !writing && resetDone_q; // see R15
  assign readStart  = reading && !dataOe_q;
  assign extTick    = extConvClk && !extPrev_q && !chipSelect_b; // see R7, see R6
  assign intTick    = intDiv_q == DW'(DIV - 1);
  assign tick       = clockExt_q ? extTick : intTick;
  assign startConv  = writeEvent ? (state_q == ST_ACQ && extAcqHold_q && !ctrlLatch_q.acquisitionModeSel)
                                 : (state_q == ST_ACQ && !extAcqHold_q && tick && cnt_q == 4'(`ACQ_CLOCKS - 1));
  assign sarD       = (compHigh ? sar_q : sar_q & ~trial_q) | (trial_q >> 1);
  assign res.inValid  = state_q == ST_DONE;
  assign res.inData   = {cfgUni_q, cfgUni_q ? sar_q : sar_q ^ `BIPOLAR_FLIP}; // see R10
  assign res.outReady = dataOe_q && !reading && lastHigh_q;
  assign push     = res.inValid && res.inReady;
  assign headWord = res.outValid ? res.outData : '0;

  // Strobe and clock edge history, byte capture
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      writeActive_q <= 1'b0;
      extPrev_q     <= 1'b0;
      ctrlLatch_q   <= '0;
    end else begin
      writeActive_q <= writing;
      extPrev_q     <= extConvClk;
      if (writing) begin
        ctrlLatch_q <= control_byte_type'(dataIn); // see R8, see R9
      end
    end
  end

  // Internal reset time before writes are honoured
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      resetCnt_q  <= '0;
      resetDone_q <= 1'b0;
    end else if (!resetDone_q) begin
      resetCnt_q  <= resetCnt_q + 1'b1;
      resetDone_q <= resetCnt_q == RW'(`RESET_CYCLES - 1); // see R15
    end
  end

  // Clock mode
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      clockExt_q <= `RESET_CLK_EXT; // see R4, see R15
    end else if (writeEvent && ctrlLatch_q.powerModeHi) begin
      clockExt_q <= ctrlLatch_q.powerModeLo; // see R1, see R2, see R3, see R22
    end
  end

  // Power state: requested at the write, taken when the conversion ends
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      standby_q      <= 1'b0;
      shutdown_q     <= 1'b0;
      pendStandby_q  <= 1'b0;
      pendShutdown_q <= 1'b0;
    end else if (writeEvent) begin
      standby_q      <= 1'b0; // see R18
      shutdown_q     <= 1'b0; // see R19
      pendStandby_q  <= !ctrlLatch_q.powerModeHi && ctrlLatch_q.powerModeLo; // see R22, see R20
      pendShutdown_q <= !ctrlLatch_q.powerModeHi && !ctrlLatch_q.powerModeLo;
    end else if (push) begin
      standby_q      <= pendStandby_q;
      shutdown_q     <= pendShutdown_q; // see R19
      pendStandby_q  <= 1'b0;
      pendShutdown_q <= 1'b0;
    end
  end

  // Input multiplexer selection
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      posChannel_q  <= '0;
      negChannel_q  <= '0;
      negIsCommon_q <= 1'b0;
    end else if (writeEvent) begin
      posChannel_q  <= ctrlLatch_q.channelAddr & CH_MASK; // see R13, see R14
      negIsCommon_q <= ctrlLatch_q.singleEndedSel;
      if (ctrlLatch_q.singleEndedSel) begin
        negChannel_q <= '0;
      end else begin
        negChannel_q <= {ctrlLatch_q.channelAddr[2:1], !ctrlLatch_q.channelAddr[0]} & CH_MASK; // see R14
      end
    end
  end

  // Internal conversion clock divider
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      intDiv_q <= '0;
    end else if (writeEvent || startConv || intTick) begin
      intDiv_q <= '0; // see R5
    end else begin
      intDiv_q <= intDiv_q + 1'b1;
    end
  end

  // Acquisition and successive-approximation sequencer
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q      <= ST_IDLE;
      cnt_q        <= '0;
      convCycles_q <= '0;
      sar_q        <= '0;
      trial_q      <= '0;
      extAcqHold_q <= 1'b0;
      cfgUni_q     <= 1'b1;
      trackHold_q  <= 1'b0;
      dacLevel_q   <= '0;
    end else if (startConv) begin
      state_q      <= ST_CONV;
      cnt_q        <= '0;
      convCycles_q <= '0;
      sar_q        <= `SAR_START;
      trial_q      <= `SAR_START;
      extAcqHold_q <= 1'b0;
      trackHold_q  <= 1'b0;
      dacLevel_q   <= {`SAR_START, 1'b0} - 13'h1; // see R21
    end else if (writeEvent) begin
      state_q      <= ST_ACQ; // see R25
      cnt_q        <= '0;
      extAcqHold_q <= ctrlLatch_q.acquisitionModeSel;
      cfgUni_q     <= ctrlLatch_q.unipolarSel;
      trackHold_q  <= 1'b1;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
        end
        ST_ACQ: begin
          if (!extAcqHold_q && tick) begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        ST_CONV: begin
          convCycles_q <= convCycles_q + 1'b1;
          if (tick) begin
            sar_q      <= sarD;
            trial_q    <= trial_q >> 1;
            dacLevel_q <= {sarD, 1'b0} - 13'h1; // see R21
            cnt_q      <= cnt_q + 1'b1;
            if (cnt_q == 4'(`CONV_CLOCKS - 1)) begin
              state_q <= ST_DONE; // see R23
            end
          end
        end
        ST_DONE: begin
          if (res.inReady) begin
            state_q <= ST_IDLE; // see R17
          end
        end
      endcase
    end
  end

  // Read path onto the data bus
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dataOe_q   <= 1'b0;
      dataOut_q  <= 8'h00;
      lastHigh_q <= 1'b0;
    end else begin
      dataOe_q <= reading; // see R7, see R26
      if (reading) begin
        lastHigh_q <= byteHighSelect;
      end
      if (!reading) begin
        dataOut_q <= 8'h00;
      end else if (byteHighSelect) begin
        dataOut_q <= {{4{!headWord[RES_W-1] && headWord[MSB]}}, headWord[MSB:8]}; // see R11, see R12
      end else begin
        dataOut_q <= headWord[7:0];
      end
    end
  end

  // Conversion done flag, set wins over clear
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      convDone_b_q <= 1'b1; // see R15
    end else if (push) begin
      convDone_b_q <= 1'b0; // see R24
    end else if (readStart || writeEvent) begin
      convDone_b_q <= 1'b1;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  property p_int_clock;
    writeEvent && ctrlLatch_q.powerModeHi && !ctrlLatch_q.powerModeLo |=> !clockExt_q;
  endproperty
  a_int_clock: assert property (p_int_clock) else $error("internal clock not selected"); // see R1

  property p_ext_clock;
    writeEvent && ctrlLatch_q.powerModeHi && ctrlLatch_q.powerModeLo |=> clockExt_q;
  endproperty
  a_ext_clock: assert property (p_ext_clock) else $error("external clock not selected"); // see R2

  property p_keep_clock;
    writeEvent && !ctrlLatch_q.powerModeHi |=> $stable(clockExt_q);
  endproperty
  a_keep_clock: assert property (p_keep_clock) else $error("clock mode changed by power-down"); // see R3

  property p_conv_time;
    state_q == ST_DONE && $past(state_q) == ST_CONV && !clockExt_q |-> convCycles_q == 7'd65;
  endproperty
  a_conv_time: assert property (p_conv_time) else $error("internal conversion time wrong"); // see R5

  property p_cs_quiet;
    chipSelect_b |=> !dataOe_q && dataOut_q == 8'h00;
  endproperty
  a_cs_quiet: assert property (p_cs_quiet) else $error("bus driven while deselected"); // see R7

  property p_high_fill;
    reading && byteHighSelect && headWord[RES_W-1] |=> dataOe_q && dataOut_q[7:4] == 4'h0;
  endproperty
  a_high_fill: assert property (p_high_fill) else $error("unipolar high byte not zero filled"); // see R12

  property p_diff_pair;
    writeEvent && !ctrlLatch_q.singleEndedSel |=> !negIsCommon_q && negChannel_q[0] != posChannel_q[0];
  endproperty
  a_diff_pair: assert property (p_diff_pair) else $error("pair selection wrong"); // see R14

  property p_reset_quiet;
    !resetDone_q |-> state_q == ST_IDLE && convDone_b_q;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("activity during reset time"); // see R15

  property p_power_idle;
    standby_q || shutdown_q |-> state_q == ST_IDLE;
  endproperty
  a_power_idle: assert property (p_power_idle) else $error("converting while powered down"); // see R17

  property p_wake;
    writeEvent |=> !standby_q && !shutdown_q ##0 trackHold_q || state_q == ST_CONV;
  endproperty
  a_wake: assert property (p_wake) else $error("write did not wake the converter"); // see R18

  property p_conv_len;
    state_q == ST_DONE && $past(state_q) == ST_CONV |-> cnt_q == 4'd13;
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion length not 13 clocks"); // see R23

  property p_done_low;
    push |=> !convDone_b_q;
  endproperty
  a_done_low: assert property (p_done_low) else $error("done not asserted"); // see R24

  property p_abort;
    writeEvent && state_q == ST_CONV |=> state_q == ST_ACQ && trackHold_q;
  endproperty
  a_abort: assert property (p_abort) else $error("write did not abort conversion"); // see R25

  c_int_conv: cover property (state_q == ST_DONE && !clockExt_q);
  c_ext_acq: cover property (startConv && writeEvent);
  c_high_read: cover property (res.outReady && res.outValid);
  c_standby: cover property ($rose(standby_q));

endmodule

`default_nettype wire

/* bench/analog_source.sv */
/*
  Analog front end seen by the converter: fixed channel levels and a comparator.
  Assumes dacLevel is in half-LSB units and settles within one clock.
*/
`timescale 1ns/1ps
`default_nettype none

module analog_source (
  input  wire logic [12:0] dacLevel,
  input  wire logic  [2:0] posChannel,
  input  wire logic  [2:0] negChannel,
  input  wire logic        negIsCommon,
  output logic             compHigh
);
  logic [11:0] code;

  function automatic logic [11:0] level(input logic [2:0] ch);
    return 12'h1A3 + 12'(ch) * 12'h1F1;
  endfunction

  // Positive input against common, or against the other channel of the pair
  assign code = level(posChannel) - (negIsCommon ? 12'h000 : level(negChannel));
  // Input sits on an integer code, threshold lies half an LSB below it
  assign compHigh = {code, 1'b0} >= dacLevel;
endmodule

`default_nettype wire

/* bench/adc_parallel_control_port_tb.sv */
/*
  Self-checking bench of the converter control port, with an analog front end model.
  Assumes the designer's port timing: byte taken as a write ends, read data one cycle late.
*/
`timescale 1ns/1ps
`default_nettype none

module adc_parallel_control_port_tb
  import adc_port_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        csB = 1'b1, wrB = 1'b1, rdB = 1'b1, hbSel = 1'b0, extClk = 1'b0;
  logic        hostOe = 1'b0;
  logic  [7:0] hostData = 8'h00;
  logic  [7:0] lastBus = 8'h00;
  wire   [7:0] busWire;
  logic  [7:0] dataOut_q;
  logic        dataOe_q, convDone_b_q, trackHold_q, compHigh, negIsCommon_q;
  logic        standby_q, shutdown_q, clockExt_q, prevCsB = 1'b1;
  logic [12:0] dacLevel_q;
  logic  [2:0] posChannel_q, negChannel_q;
  int          badCount = 0, samplesChecked = 0, cycleCount = 0;

  adc_parallel_control_port adc_parallel_control_port_inst (
    .clk(clk), .rst_b(rst_b), .chipSelect_b(csB), .writeStrobe_b(wrB), .readStrobe_b(rdB),
    .byteHighSelect(hbSel), .extConvClk(extClk), .dataIn(busWire), .compHigh(compHigh),
    .dataOut_q(dataOut_q), .dataOe_q(dataOe_q), .convDone_b_q(convDone_b_q),
    .trackHold_q(trackHold_q), .dacLevel_q(dacLevel_q), .posChannel_q(posChannel_q),
    .negChannel_q(negChannel_q), .negIsCommon_q(negIsCommon_q), .standby_q(standby_q),
    .shutdown_q(shutdown_q), .clockExt_q(clockExt_q));

  analog_source analog_source_inst (
    .dacLevel(dacLevel_q), .posChannel(posChannel_q), .negChannel(negChannel_q),
    .negIsCommon(negIsCommon_q), .compHigh(compHigh));

  // Undriven bus shows the inverse of its last level
  assign busWire = dataOe_q ? dataOut_q : (hostOe ? hostData : ~lastBus);

  initial begin
    forever #25 clk = ~clk;
  end

  always @(posedge clk) begin
    lastBus <= busWire;
    cycleCount <= cycleCount + 1;
    if (cycleCount == 6000) begin
      badCount++;
      $display("CHECK FAILED at %0t: timeout", $time);
      wrap_up();
    end
  end

  // Bus floats while deselected and never has two drivers
  always @(negedge clk) begin
    if ((prevCsB && csB && dataOe_q) || (hostOe && dataOe_q)) begin
      badCount++;
      $display("CHECK FAILED at %0t: bus driven out of turn", $time);
    end
    prevCsB <= csB;
  end

  task automatic chk(input logic [11:0] got, input logic [11:0] exp, input string what);
    samplesChecked++;
    if (got !== exp) begin
      badCount++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  function automatic logic [11:0] lvl(input logic [2:0] ch);
    return 12'h1A3 + 12'(ch) * 12'h1F1;
  endfunction

  task automatic writeByte(input logic [7:0] b);
    @(negedge clk);
    csB = 1'b0; wrB = 1'b0; hostOe = 1'b1; hostData = b;
    @(negedge clk);
    csB = 1'b1; wrB = 1'b1; hostOe = 1'b0;
    repeat (2) @(negedge clk);
  endtask

  task automatic readByte(input logic hb, output logic [7:0] v);
    @(negedge clk);
    csB = 1'b0; rdB = 1'b0; hbSel = hb;
    @(negedge clk);
    chk(dataOe_q, 1'b1, "output enable");
    chk(convDone_b_q, 1'b1, "done after read");
    v = busWire;
    csB = 1'b1; rdB = 1'b1;
  endtask

  task automatic readResult(input logic uni, input logic [11:0] exp);
    logic [7:0] lo, hi;
    readByte(1'b0, lo);
    readByte(1'b1, hi);
    chk({hi[3:0], lo}, exp, "result");
    chk(hi[7:4], uni ? 12'h0 : {8'h00, {4{exp[11]}}}, "high fill");
  endtask

  task automatic waitDone(input int lo, input int hi);
    int n;
    n = 0;
    while (convDone_b_q !== 1'b0 && n < hi + 1) begin
      @(negedge clk);
      n++;
    end
    chk(n >= lo && n <= hi, 1'b1, "conversion time");
  endtask

  // External conversion clock, 2.5 MHz at half duty
  task automatic extTicks(input int n, input logic sel);
    csB = !sel;
    repeat (n) begin
      extClk = 1'b1;
      repeat (4) @(negedge clk);
      extClk = 1'b0;
      repeat (4) @(negedge clk);
    end
    csB = 1'b1;
  endtask

  task automatic testReset();
    chk(clockExt_q, 1'b1, "reset clock mode");
    chk(convDone_b_q, 1'b1, "reset done");
    writeByte(8'h9D);
    chk(trackHold_q, 1'b0, "early write refused");
    chk(clockExt_q, 1'b1, "early write refused");
    while (cycleCount < 1010) @(negedge clk);
  endtask

  task automatic testInternal();
    writeByte(8'h9D);
    chk(clockExt_q, 1'b0, "internal clock");
    chk({posChannel_q, negIsCommon_q}, {3'd5, 1'b1}, "single-ended mux");
    waitDone(75, 90);
    readResult(1'b1, lvl(5));
    writeByte(8'h83);
    chk({posChannel_q, negChannel_q, negIsCommon_q}, {3'd3, 3'd2, 1'b0}, "pair mux");
    waitDone(75, 90);
    readResult(1'b0, (lvl(3) - lvl(2)) ^ 12'h800);
    writeByte(8'h82);
    chk({posChannel_q, negChannel_q}, {3'd2, 3'd3}, "pair swapped");
    waitDone(75, 90);
    readResult(1'b0, (lvl(2) - lvl(3)) ^ 12'h800);
  endtask

  task automatic testAbort();
    writeByte(8'h9D);
    repeat (40) @(negedge clk);
    writeByte(8'h9A);
    waitDone(75, 90);
    readResult(1'b1, lvl(2));
  endtask

  task automatic testExternal();
    writeByte(8'hD9);
    chk(clockExt_q, 1'b1, "external clock");
    extTicks(20, 1'b0);
    chk({trackHold_q, convDone_b_q}, 2'b11, "deselected clock ignored");
    extTicks(15, 1'b1);
    chk(convDone_b_q, 1'b1, "fifteen ticks");
    extTicks(1, 1'b1);
    chk(convDone_b_q, 1'b0, "sixteen ticks");
    readResult(1'b1, lvl(1));
  endtask

  // Two-write acquisition: hold until the second byte starts the conversion
  task automatic testExtAcq();
    writeByte(8'hB9);
    repeat (50) @(negedge clk);
    chk({trackHold_q, convDone_b_q}, 2'b11, "external acquisition holds");
    writeByte(8'h99);
    waitDone(60, 70);
    readResult(1'b1, lvl(1));
  endtask

  task automatic testPower();
    writeByte(8'h58);
    chk(clockExt_q, 1'b1, "standby keeps clock");
    extTicks(16, 1'b1);
    readResult(1'b1, lvl(0));
    chk(standby_q, 1'b1, "standby");
    repeat (100) @(negedge clk);
    chk(convDone_b_q, 1'b1, "no conversion in standby");
    writeByte(8'h98);
    chk({standby_q, clockExt_q}, 2'b00, "wake from standby");
    waitDone(75, 90);
    readResult(1'b1, lvl(0));
    writeByte(8'h18);
    chk(shutdown_q, 1'b0, "shutdown waits");
    waitDone(75, 90);
    chk({shutdown_q, clockExt_q}, 2'b10, "shutdown");
    readResult(1'b1, lvl(0));
    writeByte(8'h9D);
    chk(shutdown_q, 1'b0, "wake from shutdown");
    waitDone(75, 90);
    readResult(1'b1, lvl(5));
  endtask

  // Third result stalls behind two queued ones
  task automatic testBuffer();
    for (int i = 0; i < 3; i++) begin
      writeByte(8'h98 | 8'(i));
      repeat (90) @(negedge clk);
    end
    for (int i = 0; i < 3; i++) begin
      readResult(1'b1, lvl(3'(i)));
      repeat (90) @(negedge clk);
    end
  endtask

  task automatic wrap_up();
    if (badCount == 0 && samplesChecked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (3) @(negedge clk);
    rst_b = 1'b1;
    testReset();
    testInternal();
    testAbort();
    testExternal();
    testPower();
    testExtAcq();
    testBuffer();
    wrap_up();
  end
endmodule

`default_nettype wire
